// [acps_device.sv]
// Overview of operation
// R1: Reset held 1 ms; valid low 300 ns after.
// R2: Control port ready 3.5 ms after reset release.
// R3: Start-up command to running takes 10 ms minimum.
// R4: Reset ignored while powered down.
// R5: Power-down ignored while held in reset.
// R6: Power-down held low 800 ns minimum.
// R7: Power-down: valid low 725 us; wake 120 ms.
// R8: Fault pulse low at least 350 ns.
// R9: Outputs forced low 350 ns after fault.
// R10: Programmable hold, recover only if fault cleared.
// R11: Mute ramp: steps times step size.
// R12: Step is 4, 8 or 16 frames.
// R13: Headphone select held 350 ns minimum.
// R14: Headphone outputs off on low only if enabled.
// R15: Headphone switch uses programmed volume rate.
// R16: 32 to 64 bit clocks per frame.
// R17: Soft ramp around headphone switch-over.
module acps_device import acps_pkg::*; #(
    parameter int CTRL_READY_CYC = C_CTRL_READY,
    parameter int RUN_CYC = C_RUN,
    parameter int PDN_VALID_CYC = C_PDN_VALID,
    parameter int STARTUP_CYC = C_STARTUP,
    parameter int MS_CYC = C_MS
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    // Link to the controller
    acps_if.dev lnk,
    // Local status
    output logic dev_powered_down,
    output logic dev_fault_hold
);

    acps_dev_state_t state_reg;
    logic [CNT_W-1:0] tmr_reg;
    logic [SC_W-1:0] rstc_reg;
    logic [SC_W-1:0] pdc_reg;
    logic [SC_W-1:0] flc_reg;
    logic [SC_W-1:0] hpc_reg;
    logic [CNT_W-1:0] msc_reg;
    logic [HOLD_W-1:0] hold_reg;
    logic [4:0] spc_reg;
    logic fr_q_reg;
    logic hp_req_reg;
    logic hp_active_reg;
    logic rst_low;
    logic rst_hit;
    logic pdn_low;
    logic pdn_hit;
    logic pdn_ok;
    logic flt_hit;
    logic fr_rise;
    logic to_zero;
    logic [LVL_W-1:0] target;

    // Reset is not seen at all once powered down
    assign rst_low = !lnk.reset_n && state_reg != S_DOWN; // [R4]
    assign rst_hit = rst_low && rstc_reg == SC_W'(C_RST_VALID - 1);
    // Power-down is not counted while held in reset
    assign pdn_low = !lnk.power_down_n && state_reg != S_RESET && !rst_low; // [R5]
    assign pdn_hit = pdn_low && pdc_reg == SC_W'(C_PDN_MIN - 1); // [R6]
    assign pdn_ok = state_reg inside {S_BOOT, S_IDLE, S_START, S_RUN, S_WAKE};
    assign flt_hit = !lnk.backend_fault_n && flc_reg == SC_W'(C_FAULT_REACT - 1);
    assign fr_rise = lnk.frame_clk && !fr_q_reg;

    // Pin qualifiers, each saturating at its recognition count
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rstc_reg <= '0;
            pdc_reg <= '0;
            flc_reg <= '0;
        end else if (ce) begin
            if (!rst_low)
                rstc_reg <= '0;
            else if (!rst_hit)
                rstc_reg <= rstc_reg + 1'b1; // [R1]
            if (!pdn_low)
                pdc_reg <= '0;
            else if (!pdn_hit)
                pdc_reg <= pdc_reg + 1'b1;
            if (lnk.backend_fault_n)
                flc_reg <= '0;
            else if (!flt_hit)
                flc_reg <= flc_reg + 1'b1; // [R9]
        end
    end

    // Power sequencing
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= S_RESET;
            tmr_reg <= '0;
            lnk.stage_valid <= 1'b0;
            lnk.ctrl_ready <= 1'b0;
            lnk.running <= 1'b0;
            dev_powered_down <= 1'b0;
        end else if (ce) begin
            tmr_reg <= tmr_reg + 1'b1;
            if (rst_hit) begin
                state_reg <= S_RESET;
                tmr_reg <= '0;
                lnk.stage_valid <= 1'b0; // [R1]
                lnk.ctrl_ready <= 1'b0;
                lnk.running <= 1'b0;
            end else if (pdn_hit && pdn_ok) begin
                state_reg <= S_PDN_FALL; // [R7]
                tmr_reg <= '0;
            end else begin
                unique case (state_reg)
                    S_RESET: begin
                        tmr_reg <= '0;
                        if (lnk.reset_n)
                            state_reg <= S_BOOT;
                    end
                    S_BOOT: begin
                        if (tmr_reg == CNT_W'(CTRL_READY_CYC - 1)) begin
                            lnk.ctrl_ready <= 1'b1; // [R2]
                            state_reg <= S_IDLE;
                        end
                    end
                    S_IDLE: begin
                        tmr_reg <= '0;
                        if (lnk.start_cmd)
                            state_reg <= S_START;
                    end
                    S_START: begin
                        if (tmr_reg == CNT_W'(RUN_CYC - 1)) begin
                            lnk.running <= 1'b1; // [R3]
                            lnk.stage_valid <= 1'b1;
                            state_reg <= S_RUN;
                        end
                    end
                    S_RUN: begin
                        tmr_reg <= '0;
                    end
                    S_PDN_FALL: begin
                        if (tmr_reg == CNT_W'(PDN_VALID_CYC - 1)) begin
                            lnk.stage_valid <= 1'b0; // [R7]
                            lnk.running <= 1'b0;
                            dev_powered_down <= 1'b1;
                            state_reg <= S_DOWN;
                        end
                    end
                    S_DOWN: begin
                        tmr_reg <= '0;
                        if (lnk.power_down_n) begin
                            dev_powered_down <= 1'b0;
                            state_reg <= S_WAKE;
                        end
                    end
                    S_WAKE: begin
                        if (tmr_reg == CNT_W'(STARTUP_CYC - 1)) begin
                            lnk.running <= 1'b1; // [R7]
                            lnk.stage_valid <= 1'b1;
                            lnk.ctrl_ready <= 1'b1;
                            state_reg <= S_RUN;
                        end
                    end
                endcase
            end
        end
    end

    // Fault hold; the pin is checked only once the hold has run out,
    // so a fault still low at that point simply extends the hold
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            dev_fault_hold <= 1'b0;
            hold_reg <= '0;
            msc_reg <= '0;
            lnk.stage_out_en <= 1'b0;
        end else if (ce) begin
            lnk.stage_out_en <= lnk.stage_valid && !dev_fault_hold && !flt_hit;
            if (flt_hit && !dev_fault_hold) begin
                dev_fault_hold <= 1'b1; // [R9]
                hold_reg <= lnk.cfg_hold_ms; // [R10]
                msc_reg <= '0;
            end else if (dev_fault_hold) begin
                if (hold_reg != '0) begin
                    if (msc_reg == CNT_W'(MS_CYC - 1)) begin
                        msc_reg <= '0;
                        hold_reg <= hold_reg - 1'b1;
                    end else begin
                        msc_reg <= msc_reg + 1'b1;
                    end
                end else if (lnk.backend_fault_n) begin
                    dev_fault_hold <= 1'b0; // [R10]
                end
            end
        end
    end

    // Headphone select qualification
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            hp_req_reg <= 1'b0;
            hpc_reg <= '0;
        end else if (ce) begin
            if (lnk.headphone_select == hp_req_reg) begin
                hpc_reg <= '0;
            end else if (hpc_reg == SC_W'(C_HP_MIN - 1)) begin
                hp_req_reg <= lnk.headphone_select; // [R13]
                hpc_reg <= '0;
            end else begin
                hpc_reg <= hpc_reg + 1'b1;
            end
        end
    end

    // Ramp to zero on mute, when not running, or while a switch-over waits
    assign to_zero = lnk.mute || !lnk.running || hp_req_reg != hp_active_reg; // [R17]
    assign target = to_zero ? '0 : lnk.cfg_steps; // [R11]

    // Volume ramp, one level per step of frames
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            fr_q_reg <= 1'b0;
            spc_reg <= '0;
            lnk.vol_level <= '0;
        end else if (ce) begin
            fr_q_reg <= lnk.frame_clk;
            if (fr_rise) begin
                if (spc_reg >= step_frames(lnk.cfg_rate) - 5'h01) begin
                    spc_reg <= '0; // [R12] [R15]
                    if (lnk.vol_level > target)
                        lnk.vol_level <= lnk.vol_level - 1'b1; // [R11]
                    else if (lnk.vol_level < target)
                        lnk.vol_level <= lnk.vol_level + 1'b1;
                end else begin
                    spc_reg <= spc_reg + 1'b1;
                end
            end
        end
    end

    // Switch-over only at zero level, so no audible step
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            hp_active_reg <= 1'b0;
            lnk.headphone_pwm_out <= 1'b0;
        end else if (ce) begin
            if (hp_req_reg != hp_active_reg && lnk.vol_level == '0)
                hp_active_reg <= hp_req_reg; // [R17]
            lnk.headphone_pwm_out <= hp_active_reg || !lnk.cfg_hp_line_disable; // [R14]
        end
    end

endmodule

// [acps_pkg.sv]
package acps_pkg;

    // Clock base
    localparam int CLK_HZ = 10_000_000;
    localparam int CLK_NS = 1_000_000_000 / CLK_HZ;

    // Least times round up, typical and longest times round down
    function automatic int cyc_ceil(input int ns);
        return ((ns + CLK_NS - 1) / CLK_NS < 1) ? 1 : (ns + CLK_NS - 1) / CLK_NS;
    endfunction

    function automatic int cyc_floor(input int ns);
        return (ns / CLK_NS < 1) ? 1 : ns / CLK_NS;
    endfunction

    // Pin timing
    localparam int T_RST_VALID_NS = 300;
    localparam int C_RST_VALID = cyc_floor(T_RST_VALID_NS);
    localparam int T_RST_PULSE_MS = 1;
    localparam int C_RST_PULSE = cyc_ceil(T_RST_PULSE_MS * 1_000_000);
    localparam int T_CTRL_READY_US = 3500;
    localparam int C_CTRL_READY = cyc_floor(T_CTRL_READY_US * 1000);
    localparam int T_RUN_MS = 10;
    localparam int C_RUN = cyc_ceil(T_RUN_MS * 1_000_000);
    localparam int T_PDN_MIN_NS = 800;
    localparam int C_PDN_MIN = cyc_ceil(T_PDN_MIN_NS);
    localparam int T_PDN_VALID_US = 725;
    localparam int C_PDN_VALID = cyc_floor(T_PDN_VALID_US * 1000);
    localparam int T_STARTUP_MS = 120;
    localparam int C_STARTUP = cyc_floor(T_STARTUP_MS * 1_000_000);
    localparam int T_FAULT_MIN_NS = 350;
    localparam int C_FAULT_MIN = cyc_ceil(T_FAULT_MIN_NS);
    localparam int T_FAULT_REACT_NS = 350;
    localparam int C_FAULT_REACT = cyc_floor(T_FAULT_REACT_NS);
    localparam int T_HP_MIN_NS = 350;
    localparam int C_HP_MIN = cyc_ceil(T_HP_MIN_NS);
    localparam int T_MS_NS = 1_000_000;
    localparam int C_MS = cyc_floor(T_MS_NS);

    // Widths and defaults
    localparam int CNT_W = 21;
    localparam int SC_W = 4;
    localparam int LVL_W = 11;
    localparam int HOLD_W = 8;
    localparam int VOL_STEPS = 1024;
    localparam int BITS_PER_FRAME_DEF = 64;

    // Sample-rate classes and volume step length in frames
    localparam logic [1:0] RATE_NORMAL = 2'h0;
    localparam logic [1:0] RATE_DOUBLE = 2'h1;
    localparam logic [1:0] RATE_QUAD = 2'h2;
    localparam logic [4:0] STEP_FR_NORMAL = 5'h04;
    localparam logic [4:0] STEP_FR_DOUBLE = 5'h08;
    localparam logic [4:0] STEP_FR_QUAD = 5'h10;

    function automatic logic [4:0] step_frames(input logic [1:0] rate);
        case (rate)
            RATE_DOUBLE: return STEP_FR_DOUBLE;
            RATE_QUAD: return STEP_FR_QUAD;
            default: return STEP_FR_NORMAL;
        endcase
    endfunction

    // Controller register map
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CFG = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_INT_STATUS = 8'h0C;
    localparam logic [7:0] REG_INT_MASK = 8'h10;
    localparam int CTRL_RESET = 0;
    localparam int CTRL_PDN = 1;
    localparam int CTRL_START = 2;
    localparam int CTRL_MUTE = 3;
    localparam int CTRL_HEADPHONE_SELECT = 4;
    localparam int CTRL_FAULT = 5;
    localparam int CFG_HOLD_LSB = 0;
    localparam int CFG_STEPS_LSB = 8;
    localparam int CFG_RATE_LSB = 20;
    localparam int CFG_HPDIS = 24;
    localparam int STAT_LVL_LSB = 16;
    localparam logic [HOLD_W-1:0] HOLD_RST = 8'h01;
    localparam logic [LVL_W-1:0] STEPS_RST = 11'h400;
    localparam int INT_W = 4;

    // Device sequencing states
    typedef enum logic [7:0] {
        S_RESET = 8'h01,
        S_BOOT = 8'h02,
        S_IDLE = 8'h04,
        S_START = 8'h08,
        S_RUN = 8'h10,
        S_PDN_FALL = 8'h20,
        S_DOWN = 8'h40,
        S_WAKE = 8'h80
    } acps_dev_state_t;

endpackage

// [acps_if.sv]
interface acps_if;
    import acps_pkg::*;
    // Controller to device
    logic reset_n;
    logic power_down_n;
    logic backend_fault_n;
    logic headphone_select;
    logic mute;
    logic start_cmd;
    logic frame_clk;
    logic bit_clk;
    logic [HOLD_W-1:0] cfg_hold_ms;
    logic [LVL_W-1:0] cfg_steps;
    logic [1:0] cfg_rate;
    logic cfg_hp_line_disable;
    // Device to controller
    logic stage_valid;
    logic stage_out_en;
    logic headphone_pwm_out;
    logic ctrl_ready;
    logic running;
    logic [LVL_W-1:0] vol_level;

    modport dev (
        input reset_n, power_down_n, backend_fault_n, headphone_select, mute,
        input start_cmd, frame_clk, bit_clk, cfg_hold_ms, cfg_steps, cfg_rate,
        input cfg_hp_line_disable,
        output stage_valid, stage_out_en, headphone_pwm_out, ctrl_ready,
        output running, vol_level
    );

    modport host (
        output reset_n, power_down_n, backend_fault_n, headphone_select, mute,
        output start_cmd, frame_clk, bit_clk, cfg_hold_ms, cfg_steps, cfg_rate,
        output cfg_hp_line_disable,
        input stage_valid, stage_out_en, headphone_pwm_out, ctrl_ready,
        input running, vol_level
    );
endinterface

// [acps_host.sv]
module acps_host import acps_pkg::*; #(
    parameter int RST_PULSE_CYC = C_RST_PULSE,
    parameter int BITS_PER_FRAME = BITS_PER_FRAME_DEF
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    // Link to the amplifier
    acps_if.host lnk,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    output logic irq,
    // Power stage fault, active low
    input wire logic stage_fault_n
);

    logic pdn_req_reg;
    logic flt_req_reg;
    logic hp_req_reg;
    logic [CNT_W-1:0] rpc_reg;
    logic [SC_W-1:0] pdc_reg;
    logic [SC_W-1:0] flc_reg;
    logic [SC_W-1:0] hsc_reg;
    logic [6:0] bitc_reg;
    logic [INT_W-1:0] int_stat_reg;
    logic [INT_W-1:0] int_mask_reg;
    logic [INT_W-1:0] int_ev;
    logic valid_q_reg;
    logic ready_q_reg;
    logic oe_q_reg;
    logic wr_ctrl;
    logic flt_src;

    assign wr_ctrl = wr && addr == REG_CTRL;
    assign flt_src = flt_req_reg || !stage_fault_n;

    // Control and configuration registers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pdn_req_reg <= 1'b0;
            flt_req_reg <= 1'b0;
            hp_req_reg <= 1'b0;
            lnk.mute <= 1'b0;
            lnk.start_cmd <= 1'b0;
            lnk.cfg_hold_ms <= HOLD_RST;
            lnk.cfg_steps <= STEPS_RST;
            lnk.cfg_rate <= RATE_NORMAL;
            lnk.cfg_hp_line_disable <= 1'b0;
        end else if (ce) begin
            lnk.start_cmd <= wr_ctrl && wdata[CTRL_START];
            if (wr_ctrl) begin
                pdn_req_reg <= wdata[CTRL_PDN];
                lnk.mute <= wdata[CTRL_MUTE];
                hp_req_reg <= wdata[CTRL_HEADPHONE_SELECT];
                flt_req_reg <= wdata[CTRL_FAULT];
            end
            if (wr && addr == REG_CFG) begin
                lnk.cfg_hold_ms <= wdata[CFG_HOLD_LSB +: HOLD_W];
                lnk.cfg_steps <= wdata[CFG_STEPS_LSB +: LVL_W];
                lnk.cfg_rate <= wdata[CFG_RATE_LSB +: 2];
                lnk.cfg_hp_line_disable <= wdata[CFG_HPDIS];
            end
        end
    end

    // Reset pulse of fixed length on request
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lnk.reset_n <= 1'b1;
            rpc_reg <= '0;
        end else if (ce) begin
            if (wr_ctrl && wdata[CTRL_RESET]) begin
                lnk.reset_n <= 1'b0; // [R1]
                rpc_reg <= '0;
            end else if (!lnk.reset_n) begin
                if (rpc_reg == CNT_W'(RST_PULSE_CYC - 1))
                    lnk.reset_n <= 1'b1;
                rpc_reg <= rpc_reg + 1'b1;
            end
        end
    end

    // Pin levels each held for their least width before release
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lnk.power_down_n <= 1'b1;
            lnk.backend_fault_n <= 1'b1;
            lnk.headphone_select <= 1'b0;
            pdc_reg <= '0;
            flc_reg <= '0;
            hsc_reg <= '0;
        end else if (ce) begin
            if (pdn_req_reg) begin
                lnk.power_down_n <= 1'b0;
            end else if (pdc_reg >= SC_W'(C_PDN_MIN - 1)) begin
                lnk.power_down_n <= 1'b1; // [R6]
            end
            pdc_reg <= lnk.power_down_n ? '0 : pdc_reg + SC_W'(pdc_reg != '1);
            if (flt_src) begin
                lnk.backend_fault_n <= 1'b0;
            end else if (flc_reg >= SC_W'(C_FAULT_MIN - 1)) begin
                lnk.backend_fault_n <= 1'b1; // [R8]
            end
            flc_reg <= lnk.backend_fault_n ? '0 : flc_reg + SC_W'(flc_reg != '1);
            if (hp_req_reg != lnk.headphone_select
                && hsc_reg >= SC_W'(C_HP_MIN - 1)) begin
                lnk.headphone_select <= hp_req_reg; // [R13]
                hsc_reg <= '0;
            end else begin
                hsc_reg <= hsc_reg + SC_W'(hsc_reg != '1);
            end
        end
    end

    // Bit clock at half the system rate, frame clock every BITS_PER_FRAME bits
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lnk.bit_clk <= 1'b0;
            lnk.frame_clk <= 1'b0;
            bitc_reg <= '0;
        end else if (ce) begin
            lnk.bit_clk <= !lnk.bit_clk;
            if (lnk.bit_clk) begin
                bitc_reg <= (bitc_reg == 7'(BITS_PER_FRAME - 1)) ? '0 : bitc_reg + 1'b1; // [R16]
                lnk.frame_clk <= bitc_reg >= 7'(BITS_PER_FRAME / 2 - 1)
                    && bitc_reg != 7'(BITS_PER_FRAME - 1);
            end
        end
    end

    // Events: valid fell, valid rose, control port ready, outputs cut
    assign int_ev = {oe_q_reg && !lnk.stage_out_en && lnk.stage_valid,
                     !ready_q_reg && lnk.ctrl_ready,
                     !valid_q_reg && lnk.stage_valid,
                     valid_q_reg && !lnk.stage_valid};

    // Set wins over a write-one clear in the same cycle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            valid_q_reg <= 1'b0;
            ready_q_reg <= 1'b0;
            oe_q_reg <= 1'b0;
            int_stat_reg <= '0;
            int_mask_reg <= '0;
            irq <= 1'b0;
        end else if (ce) begin
            valid_q_reg <= lnk.stage_valid;
            ready_q_reg <= lnk.ctrl_ready;
            oe_q_reg <= lnk.stage_out_en;
            if (wr && addr == REG_INT_STATUS)
                int_stat_reg <= (int_stat_reg & ~wdata[INT_W-1:0]) | int_ev;
            else
                int_stat_reg <= int_stat_reg | int_ev;
            if (wr && addr == REG_INT_MASK)
                int_mask_reg <= wdata[INT_W-1:0];
            irq <= |(int_stat_reg & int_mask_reg);
        end
    end

    // Read data one cycle after the strobe, zero for unmapped addresses
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata <= '0;
        end else if (ce) begin
            rdata <= '0;
            if (rd) begin
                unique case (addr)
                    REG_CTRL: rdata <= 32'({flt_req_reg, hp_req_reg, lnk.mute, 1'b0,
                                            pdn_req_reg, !lnk.reset_n});
                    REG_CFG: rdata <= 32'({lnk.cfg_hp_line_disable, 2'h0, lnk.cfg_rate,
                                           1'b0, lnk.cfg_steps, lnk.cfg_hold_ms});
                    REG_STATUS: rdata <= 32'({lnk.vol_level, 11'h000, lnk.headphone_pwm_out,
                                              lnk.running, lnk.ctrl_ready,
                                              lnk.stage_out_en, lnk.stage_valid});
                    REG_INT_STATUS: rdata <= 32'(int_stat_reg);
                    REG_INT_MASK: rdata <= 32'(int_mask_reg);
                    default: rdata <= '0;
                endcase
            end
        end
    end

endmodule

// [acps_chk.sv]
module acps_chk import acps_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Link signals
    input wire logic reset_n,
    input wire logic power_down_n,
    input wire logic backend_fault_n,
    input wire logic start_cmd,
    input wire logic stage_valid,
    input wire logic stage_out_en,
    input wire logic ctrl_ready,
    input wire logic running,
    input wire logic [LVL_W-1:0] vol_level
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_rst_valid; $fell(reset_n) |-> ##3 !stage_valid; endproperty
    a_rst_valid: assert property (p_rst_valid) else $error("valid late");
    property p_boot; $rose(reset_n) && !ctrl_ready |-> !ctrl_ready [*8]; endproperty
    a_boot: assert property (p_boot) else $error("ready early");
    property p_start; start_cmd && !running |-> !running [*8]; endproperty
    a_start: assert property (p_start) else $error("run early");
    sequence s_pdn; $fell(power_down_n) ##1 !power_down_n [*7]; endsequence
    property p_pdn; s_pdn |-> ##[1:45] !stage_valid; endproperty
    a_pdn: assert property (p_pdn) else $error("pdn valid");
    property p_cut; $fell(backend_fault_n) |-> ##3 !stage_out_en; endproperty
    a_cut: assert property (p_cut) else $error("no cut");
    property p_rec; $rose(stage_out_en) |-> $past(backend_fault_n); endproperty
    a_rec: assert property (p_rec) else $error("bad recovery");
    property p_vstep;
        running && $past(running) && $changed(vol_level)
            |-> (vol_level - $past(vol_level)) inside {11'h001, 11'h7FF};
    endproperty
    a_vstep: assert property (p_vstep) else $error("vol jump");
    property p_vgap; running && $changed(vol_level) |=> $stable(vol_level) [*8]; endproperty
    a_vgap: assert property (p_vgap) else $error("vol fast");
    c_cut: cover property ($fell(stage_out_en));
    c_pdn: cover property (s_pdn);
    c_vol: cover property (running && $changed(vol_level));
endmodule

// [tb.sv]
module tb;
    import acps_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, sys_rst = 1, ce = 1, wr = 0, rd = 0, flt_n = 1, irq, pdn_st, fh;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    int fail_count = 0, checks_done = 0, n;
    acps_if lnk();
    wire [15:0] mon = {lnk.vol_level, lnk.backend_fault_n, lnk.running, lnk.stage_valid,
        lnk.stage_out_en, lnk.ctrl_ready};
    acps_host #(.RST_PULSE_CYC(20)) acps_host_i (.clk(clk), .sys_rst(sys_rst), .ce(ce),
        .lnk(lnk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
        .stage_fault_n(flt_n));
    acps_device #(.CTRL_READY_CYC(40), .RUN_CYC(50), .PDN_VALID_CYC(30), .STARTUP_CYC(60))
        acps_device_i (.clk(clk), .sys_rst(sys_rst), .ce(ce), .lnk(lnk),
        .dev_powered_down(pdn_st), .dev_fault_hold(fh));
    acps_chk acps_chk_i (.clk(clk), .sys_rst(sys_rst), .reset_n(lnk.reset_n),
        .power_down_n(lnk.power_down_n), .backend_fault_n(lnk.backend_fault_n),
        .start_cmd(lnk.start_cmd), .stage_valid(lnk.stage_valid),
        .stage_out_en(lnk.stage_out_en), .ctrl_ready(lnk.ctrl_ready),
        .running(lnk.running), .vol_level(lnk.vol_level));
    always #50 clk = ~clk;
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a, input logic [31:0] m, exp, input string nm);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(nm, rdata & m, exp);
    endtask
    // Bounded poll; a stuck design cannot hang
    task automatic wt(input string nm, input logic [15:0] m, v, input int lim);
        n = 0;
        while ((mon & m) !== v && n < lim) begin
            @(posedge clk);
            #1 n++;
        end
        chk(nm, mon & m, v);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (80000) @(posedge clk);
        fail_count++;
        tally_and_finish;
    end
    initial begin
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        rreg(REG_CFG, 32'hFFFF_FFFF, 32'h0004_0001, "cfg");
        wreg(REG_INT_MASK, 32'h0000_000C);
        wt("ready", 16'h0001, 16'h0001, 100);
        rreg(REG_INT_STATUS, 32'h0000_0004, 32'h0000_0004, "ready_ev");
        chk("irq", irq, 1'b1);
        wreg(REG_INT_STATUS, 32'h0000_0004);
        wreg(REG_CFG, 32'h0000_0402);
        chk("irq_clr", irq, 1'b0);
        wreg(REG_CTRL, 32'h0000_0004);
        wt("run", 16'h0008, 16'h0008, 200);
        chk("run_t", n >= 45, 1'b1);
        wt("vol", 16'hFFE0, 16'h0080, 3000);
        // Shorter ramp keeps the quad-rate pass affordable
        for (int r = 0; r < 3; r++) begin
            wreg(REG_CFG, 32'h0000_0402 | (r << 20));
            wreg(REG_CTRL, 32'h0000_0008);
            wt("vol3", 16'hFFE0, 16'h0060, 5000);
            wt("vol2", 16'hFFE0, 16'h0040, 3000);
            chk("step", n, 32'h0000_0200 << r);
            wt("vol0", 16'hFFE0, 16'h0000, 9000);
            wreg(REG_CTRL, 32'h0000_0000);
            wt("vol4", 16'hFFE0, 16'h0080, 9000);
        end
        rreg(REG_STATUS, 32'h0000_0010, 32'h0000_0010, "hp_on");
        wreg(REG_CFG, 32'h0100_0402);
        rreg(REG_STATUS, 32'h0000_0010, 32'h0000_0000, "hp_off");
        wreg(REG_CTRL, 32'h0000_0010);
        wt("hp0", 16'hFFE0, 16'h0000, 3000);
        wt("hp4", 16'hFFE0, 16'h0080, 3000);
        rreg(REG_STATUS, 32'h0000_0010, 32'h0000_0010, "hp_sel");
        wreg(REG_CFG, 32'h0000_0401);
        @(posedge clk);
        flt_n <= 1'b0;
        wt("flt", 16'h0010, 16'h0000, 8);
        wt("cut", 16'h0002, 16'h0000, 4);
        repeat (40) @(posedge clk);
        chk("hold", mon[1], 1'b0);
        chk("fh", fh, 1'b1);
        flt_n <= 1'b1;
        wt("rec", 16'h0002, 16'h0002, 10100);
        rreg(REG_INT_STATUS, 32'h0000_0008, 32'h0000_0008, "cut_ev");
        chk("irq_cut", irq, 1'b1);
        wreg(REG_CTRL, 32'h0000_0002);
        wt("pdn", 16'h0004, 16'h0000, 60);
        wreg(REG_CTRL, 32'h0000_0003);
        repeat (30) @(posedge clk);
        chk("rst_ign", pdn_st, 1'b1);
        wreg(REG_CTRL, 32'h0000_0000);
        wt("wake", 16'h0004, 16'h0004, 120);
        wreg(REG_CTRL, 32'h0000_0001);
        wreg(REG_CTRL, 32'h0000_0002);
        repeat (12) @(posedge clk);
        wreg(REG_CTRL, 32'h0000_0000);
        wt("reboot", 16'h0001, 16'h0001, 200);
        chk("pdn_ign", pdn_st, 1'b0);
        rreg(8'h20, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped");
        @(posedge clk);
        ce <= 1'b0;
        wreg(REG_CTRL, 32'h0000_0001);
        ce <= 1'b1;
        rreg(REG_CTRL, 32'h0000_0001, 32'h0000_0000, "ce_frz");
        tally_and_finish;
    end
endmodule
